// file: spindle_pkg.sv
// Register map, field positions and timing constants of the spindle register bank
package spindle_pkg;
  localparam logic [7:0] OFF_DELAY = 8'h3E;
  localparam logic [7:0] OFF_COARSE = 8'h4E;
  localparam logic [7:0] OFF_CF = 8'h5E;
  localparam logic [7:0] OFF_FINE = 8'h6E;
  localparam logic [7:0] OFF_STATUS = 8'h7E;
  localparam logic [7:0] OFF_LOOP = 8'h8E;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam int FRAME_BITS = 16;
  localparam int HEAD_BITS = 8;
  localparam int RW_BIT = 0;
  localparam int D_MASK = 0;
  localparam int D_MIN_LO = 1;
  localparam int D_MIN_HI = 2;
  localparam int D_POLE = 3;
  localparam int D_CD_MSB = 4;
  localparam int CF_FINE_HI = 0;
  localparam int CF_BRAKE = 3;
  localparam int CF_COARSE_LO = 4;
  localparam int L_SLEW = 0;
  localparam int L_PUMP_I = 1;
  localparam int L_SENSE = 3;
  localparam int L_LIMIT_SEL_HI = 4;
  localparam int L_LIMIT_SEL_LO = 5;
  localparam int L_PUMP_DN = 6;
  localparam int L_PUMP_UP = 7;
  localparam int ST_THERM = 0;
  localparam int ST_WARN = 1;
  localparam int ST_STALL = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_MASK = 4;
  localparam int ST_SPEED = 5;
  localparam int ST_ALIGN = 6;
  localparam int ST_GO = 7;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MIN_ON_00_NS = 5900;
  localparam int MIN_ON_01_NS = 1400;
  localparam int MIN_ON_10_NS = 12000;
  localparam int MIN_ON_11_NS = 5210;
  localparam int MIN_ON_00_CYC = (MIN_ON_00_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_ON_01_CYC = (MIN_ON_01_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_ON_10_CYC = (MIN_ON_10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_ON_11_CYC = (MIN_ON_11_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPEED_LIMIT_MS = 16;
  localparam int SPEED_LIMIT_CYC = SPEED_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int MASK_WIDE_MDEG = 15000;
  localparam int MASK_NARROW_MDEG = 7500;
  localparam int COMMUT_STEP_MDEG = 1875;
  localparam logic [9:0] LIMIT_MV [8] = '{10'h1C2, 10'h1F4, 10'h226, 10'h2EE,
                                         10'h096, 10'h0C8, 10'h0FA, 10'h12C};
endpackage : spindle_pkg

// file: link_bus_if.sv
// Signals passed between the serial link domain and the register core
`timescale 1ns/10ps
interface link_bus_if;
  logic wr_toggle;
  logic [spindle_pkg::FRAME_BITS-1:0] wr_word;
  logic [7:0] rd_status;
  modport link (output wr_toggle, output wr_word, input rd_status);
  modport core (input wr_toggle, input wr_word, output rd_status);
endinterface : link_bus_if

// file: serial_link.sv
// Serial host port running on the host serial clock
`timescale 1ns/10ps
module serial_link (
  input wire logic sclk_i,
  input wire logic rst_i,
  input wire logic serial_frame_enable_i,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  link_bus_if.link bus
);
  localparam int FB = spindle_pkg::FRAME_BITS;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_END = CNT_W'(FB);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FB - 1);
  localparam logic [CNT_W-1:0] CNT_HEAD = CNT_W'(spindle_pkg::HEAD_BITS);

  logic frame_clr;
  logic [CNT_W-1:0] bit_cnt_r;
  logic [FB-1:0] shift_r;
  logic [FB-1:0] word_r;
  logic toggle_r;
  logic out_r;
  logic oe_r;
  logic [7:0] rd_byte;
  logic is_read;

  if (FB != 16) begin : g_chk
    $error("serial_link serves 16-bit frames only");
  end

  // Frame low clears the bit counter and read output even with the serial clock stopped
  assign frame_clr = !serial_frame_enable_i;
  assign is_read = shift_r[spindle_pkg::RW_BIT];
  assign rd_byte = ({shift_r[7:1], 1'b0} == spindle_pkg::OFF_STATUS) ? bus.rd_status
                                                                  : spindle_pkg::READ_IDLE;

  always_ff @(posedge sclk_i or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt_r <= '0;
    end else if (bit_cnt_r != CNT_END) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sclk_i) begin
    if (bit_cnt_r != CNT_END) begin
      shift_r[bit_cnt_r[3:0]] <= serial_data_i;
    end
  end

  always_ff @(posedge sclk_i) begin
    if (bit_cnt_r == CNT_LAST) begin
      word_r <= {serial_data_i, shift_r[FB-2:0]};
    end
  end

  // Toggle only for writes; reads never disturb the core
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      toggle_r <= 1'b0;
    end else if (bit_cnt_r == CNT_LAST && !is_read) begin
      toggle_r <= ~toggle_r;
    end
  end

  // read data driven after the address byte
  always_ff @(negedge sclk_i or posedge frame_clr) begin
    if (frame_clr) begin
      oe_r <= 1'b0;
      out_r <= 1'b0;
    end else if (bit_cnt_r >= CNT_HEAD && bit_cnt_r != CNT_END && is_read) begin
      oe_r <= 1'b1;
      out_r <= rd_byte[bit_cnt_r[2:0]];
    end else begin
      oe_r <= 1'b0;
      out_r <= 1'b0;
    end
  end

  assign bus.wr_toggle = toggle_r;
  assign bus.wr_word = word_r;
  assign serial_data_o = out_r;
  assign serial_data_oe_o = oe_r;
endmodule : serial_link

// file: spindle_config_status_regs.sv
// Spindle configuration and status register bank with serial host port
`timescale 1ns/10ps
// Functional notes
// - Delay bit 0 picks BEMF mask window, 0 gives 15 degrees, 1 gives 7.5.
// - Bits 2,1 pick minimum PWM on-time: 5.9, 1.4, 12, 5.21 us.
// - Delay bit 3 picks pole count: 1 is eight poles, 0 twelve.
// - Commutation delay field has MSB at bit 4 and LSB at bit 7.
// - Commutation delay spans 1.875 to 30 degrees in 1.875 degree steps.
// - Coarse count joins 4Eh as bits 11..4 and 5Eh high nibble as 3..0.
// - Fine count joins 6Eh as bits 7..0 and 5Eh bits 2..0 as 10..8.
// - Bit 3 of 5Eh picks two-phase brake when 1, three-phase when 0.
// - Status bit 0 low on overtemperature; spindle drivers then disabled.
// - Status bit 1 low gives early overtemperature warning.
// - Status bit 2 low when no sequential BEMF seen, stall_detect_n.
// - Status bit 3 high on rapid deceleration or fast zero-cross signal.
// - Status bit 4 low while BEMF is masked, high otherwise.
// - Status bit 5 low when speed period exceeds 16 ms per sample.
// - Status bits 6 and 7 low during align and go start-up phases.
// - Loop bit 0 picks chopping slew, 0 is 10 V/us, 1 is 20.
// - Loop bit 1 picks pump current, 1 is 25 uA, 0 is 100.
// - Loop bit 3 routes sense amplifier to zero-cross pin, limit cut to third.
// - Limit bits 5,4 with sense select give the sense voltage limit.
// - Loop bit 6 forces pump low, bit 7 forces pump high.
// - Frames are sixteen bits LSB first: read flag, 7-bit address, data.
// - Word latched after sixteenth pulse; extra pulses ignored; early drop aborts.
module spindle_config_status_regs #(
  parameter int SPEED_LIMIT_CYC = spindle_pkg::SPEED_LIMIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic serial_frame_enable_i,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  input wire logic overtemp_i,
  input wire logic overtemp_early_i,
  input wire logic rotor_stall_i,
  input wire logic spin_fault_i,
  input wire logic bemf_masked_i,
  input wire logic align_phase_i,
  input wire logic go_phase_i,
  input wire logic zero_cross_i,
  input wire logic sense_amp_i,
  input wire logic pwm_req_i,
  output logic [13:0] mask_window_mdeg_o,
  output logic [8:0] min_on_cycles_o,
  output logic pole8_o,
  output logic [3:0] commut_delay_o,
  output logic [14:0] commut_delay_mdeg_o,
  output logic [11:0] coarse_count_o,
  output logic [10:0] fine_count_o,
  output logic brake_two_phase_o,
  output logic chop_edge_rate_sel_o,
  output logic pump_current_sel_o,
  output logic sense_out_select_o,
  output logic limit_third_o,
  output logic [9:0] limit_mv_o,
  output logic pump_force_down_o,
  output logic pump_force_up_o,
  output logic zero_cross_out_o,
  output logic spindle_drive_en_o,
  output logic pwm_gate_o
);
  localparam int SPD_W = 24;
  localparam logic [SPD_W-1:0] SPD_MAX = SPD_W'(SPEED_LIMIT_CYC);
  localparam int S_OT = 0;
  localparam int S_WARN = 1;
  localparam int S_STALL = 2;
  localparam int S_FAULT = 3;
  localparam int S_MASK = 4;
  localparam int S_ALIGN = 5;
  localparam int S_GO = 6;
  localparam int S_ZC = 7;
  localparam int S_SENSE = 8;
  localparam int S_PWM = 9;
  localparam int S_FRAME = 10;
  localparam int S_TGL = 11;
  localparam int NSYNC = 12;

  typedef enum logic [1:0] {
    GATE_OFF = 2'b00,
    GATE_MIN = 2'b01,
    GATE_FREE = 2'b10
  } gate_state_e;

  if (SPEED_LIMIT_CYC < 2 || SPEED_LIMIT_CYC >= (1 << SPD_W)) begin : g_chk
    $error("SPEED_LIMIT_CYC out of counter range");
  end

  link_bus_if bus ();

  serial_link u_link (
    .sclk_i(sclk_i),
    .rst_i(rst_i),
    .serial_frame_enable_i(serial_frame_enable_i),
    .serial_data_i(serial_data_i),
    .serial_data_o(serial_data_o),
    .serial_data_oe_o(serial_data_oe_o),
    .bus(bus)
  );

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  logic tgl_seen_r;
  logic wr_evt;
  logic [7:0] wr_off;
  logic [7:0] wr_data;
  logic [7:0] delay_cfg_r;
  logic [7:0] coarse_hi_r;
  logic [7:0] cf_r;
  logic [7:0] fine_lo_r;
  logic [7:0] loop_cfg_r;
  logic [7:0] status_r;
  logic [7:0] rd_status_r;
  logic [13:0] mask_mdeg_r;
  logic [8:0] min_on_r;
  logic [3:0] commut_r;
  logic [14:0] commut_mdeg_r;
  logic [9:0] limit_mv_r;
  logic zc_out_r;
  logic drive_en_r;
  logic zc_d_r;
  logic zc_rise;
  logic [SPD_W-1:0] spd_cnt_r;
  logic speed_err_r;
  gate_state_e gate_state_r;
  logic [8:0] gate_cnt_r;
  logic gate_r;
  logic [7:0] last_wr_r;
  logic [8:0] on_len_r;

  function automatic logic hit(input logic evt, input logic [7:0] off, input logic [7:0] reg_off);
    return evt && (off == reg_off);
  endfunction : hit

  function automatic logic [3:0] rev4(input logic [3:0] v);
    logic [3:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[i] = v[3 - i];
    end
    return r;
  endfunction : rev4

  function automatic logic [8:0] min_on_cyc(input logic [1:0] sel);
    case (sel)
      2'b00: return 9'(spindle_pkg::MIN_ON_00_CYC);
      2'b01: return 9'(spindle_pkg::MIN_ON_01_CYC);
      2'b10: return 9'(spindle_pkg::MIN_ON_10_CYC);
      default: return 9'(spindle_pkg::MIN_ON_11_CYC);
    endcase
  endfunction : min_on_cyc

  assign async_in = {bus.wr_toggle, serial_frame_enable_i, pwm_req_i, sense_amp_i,
                     zero_cross_i, go_phase_i, align_phase_i, bemf_masked_i,
                     spin_fault_i, rotor_stall_i, overtemp_early_i, overtemp_i};

  // Two stages for every pin except clk_i, rst_i, sclk_i and serial_data_i, and for the link toggle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tgl_seen_r <= sync_r[S_TGL];
    end else begin
      tgl_seen_r <= sync_r[S_TGL];
    end
  end

  // read flag and address ahead of data
  assign wr_evt = sync_r[S_TGL] ^ tgl_seen_r;
  assign wr_off = {bus.wr_word[spindle_pkg::HEAD_BITS-1:1], 1'b0};
  assign wr_data = bus.wr_word[spindle_pkg::FRAME_BITS-1:spindle_pkg::HEAD_BITS];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delay_cfg_r <= spindle_pkg::CFG_RESET;
      coarse_hi_r <= spindle_pkg::CFG_RESET;
      cf_r <= spindle_pkg::CFG_RESET;
      fine_lo_r <= spindle_pkg::CFG_RESET;
      loop_cfg_r <= spindle_pkg::CFG_RESET;
    end else if (hit(wr_evt, wr_off, spindle_pkg::OFF_DELAY)) begin
      delay_cfg_r <= wr_data;
    end else if (hit(wr_evt, wr_off, spindle_pkg::OFF_COARSE)) begin
      coarse_hi_r <= wr_data;
    end else if (hit(wr_evt, wr_off, spindle_pkg::OFF_CF)) begin
      cf_r <= wr_data;
    end else if (hit(wr_evt, wr_off, spindle_pkg::OFF_FINE)) begin
      fine_lo_r <= wr_data;
    end else if (hit(wr_evt, wr_off, spindle_pkg::OFF_LOOP)) begin
      loop_cfg_r <= wr_data;
    end
  end

  // Decoded settings, registered so outputs leave flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_mdeg_r <= 14'(spindle_pkg::MASK_WIDE_MDEG);
      min_on_r <= 9'(spindle_pkg::MIN_ON_00_CYC);
      commut_r <= 4'h0;
      commut_mdeg_r <= 15'(spindle_pkg::COMMUT_STEP_MDEG);
      limit_mv_r <= spindle_pkg::LIMIT_MV[0];
    end else begin
      mask_mdeg_r <= delay_cfg_r[spindle_pkg::D_MASK] ? 14'(spindle_pkg::MASK_NARROW_MDEG)
                                                      : 14'(spindle_pkg::MASK_WIDE_MDEG);
      min_on_r <= min_on_cyc({delay_cfg_r[spindle_pkg::D_MIN_HI],
                              delay_cfg_r[spindle_pkg::D_MIN_LO]});
      // bit 4 is the field MSB
      commut_r <= rev4(delay_cfg_r[spindle_pkg::D_CD_MSB +: 4]);
      commut_mdeg_r <= 15'((int'(rev4(delay_cfg_r[spindle_pkg::D_CD_MSB +: 4])) + 1)
                           * spindle_pkg::COMMUT_STEP_MDEG);
      limit_mv_r <= spindle_pkg::LIMIT_MV[{loop_cfg_r[spindle_pkg::L_SENSE],
                                           loop_cfg_r[spindle_pkg::L_LIMIT_SEL_LO],
                                           loop_cfg_r[spindle_pkg::L_LIMIT_SEL_HI]}];
    end
  end

  assign pole8_o = delay_cfg_r[spindle_pkg::D_POLE];
  assign coarse_count_o = {coarse_hi_r, cf_r[spindle_pkg::CF_COARSE_LO +: 4]};
  assign fine_count_o = {cf_r[spindle_pkg::CF_FINE_HI +: 3], fine_lo_r};
  assign brake_two_phase_o = cf_r[spindle_pkg::CF_BRAKE];
  assign chop_edge_rate_sel_o = loop_cfg_r[spindle_pkg::L_SLEW];
  assign pump_current_sel_o = loop_cfg_r[spindle_pkg::L_PUMP_I];
  assign sense_out_select_o = loop_cfg_r[spindle_pkg::L_SENSE];
  assign limit_third_o = loop_cfg_r[spindle_pkg::L_SENSE];
  assign pump_force_down_o = loop_cfg_r[spindle_pkg::L_PUMP_DN];
  assign pump_force_up_o = loop_cfg_r[spindle_pkg::L_PUMP_UP];
  assign mask_window_mdeg_o = mask_mdeg_r;
  assign min_on_cycles_o = min_on_r;
  assign commut_delay_o = commut_r;
  assign commut_delay_mdeg_o = commut_mdeg_r;
  assign limit_mv_o = limit_mv_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zc_out_r <= 1'b0;
    end else begin
      zc_out_r <= sense_out_select_o ? sync_r[S_SENSE] : sync_r[S_ZC];
    end
  end
  assign zero_cross_out_o = zc_out_r;

  assign zc_rise = sync_r[S_ZC] & ~zc_d_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zc_d_r <= 1'b0;
      spd_cnt_r <= '0;
      speed_err_r <= 1'b0;
    end else begin
      zc_d_r <= sync_r[S_ZC];
      if (zc_rise) begin
        spd_cnt_r <= '0;
      end else if (spd_cnt_r != SPD_MAX) begin
        spd_cnt_r <= spd_cnt_r + 1'b1;
      end
      speed_err_r <= (spd_cnt_r >= SPD_MAX);
    end
  end

  // Status flags follow their sources every cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= spindle_pkg::STATUS_RESET;
      drive_en_r <= 1'b0;
    end else begin
      status_r[spindle_pkg::ST_THERM] <= ~sync_r[S_OT];
      drive_en_r <= ~sync_r[S_OT];
      status_r[spindle_pkg::ST_WARN] <= ~sync_r[S_WARN];
      status_r[spindle_pkg::ST_STALL] <= ~sync_r[S_STALL];
      status_r[spindle_pkg::ST_FAULT] <= sync_r[S_FAULT];
      status_r[spindle_pkg::ST_MASK] <= ~sync_r[S_MASK];
      status_r[spindle_pkg::ST_SPEED] <= ~speed_err_r;
      status_r[spindle_pkg::ST_ALIGN] <= ~sync_r[S_ALIGN];
      status_r[spindle_pkg::ST_GO] <= ~sync_r[S_GO];
    end
  end
  assign spindle_drive_en_o = drive_en_r;

  // snapshot frozen while a frame runs, so the link sees stable bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_status_r <= spindle_pkg::STATUS_RESET;
    end else if (!sync_r[S_FRAME]) begin
      rd_status_r <= status_r;
    end
  end
  assign bus.rd_status = rd_status_r;

  // PWM pulse held for at least the minimum on-time unless drive enable drops and cuts it short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_state_r <= GATE_OFF;
      gate_cnt_r <= '0;
      gate_r <= 1'b0;
    end else if (!drive_en_r) begin
      gate_state_r <= GATE_OFF;
      gate_r <= 1'b0;
    end else begin
      case (gate_state_r)
        GATE_OFF: begin
          if (sync_r[S_PWM]) begin
            gate_state_r <= GATE_MIN;
            gate_cnt_r <= min_on_r - 1'b1;
            gate_r <= 1'b1;
          end
        end
        GATE_MIN: begin
          if (gate_cnt_r != '0) begin
            gate_cnt_r <= gate_cnt_r - 1'b1;
          end else if (sync_r[S_PWM]) begin
            gate_state_r <= GATE_FREE;
          end else begin
            gate_state_r <= GATE_OFF;
            gate_r <= 1'b0;
          end
        end
        GATE_FREE: begin
          if (!sync_r[S_PWM]) begin
            gate_state_r <= GATE_OFF;
            gate_r <= 1'b0;
          end
        end
        default: begin
          gate_state_r <= GATE_OFF;
          gate_r <= 1'b0;
        end
      endcase
    end
  end
  assign pwm_gate_o = gate_r;

  // Checker helpers: last written data and pulse length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_wr_r <= 8'h00;
      on_len_r <= '0;
    end else begin
      if (wr_evt) begin
        last_wr_r <= wr_data;
      end
      if (!gate_r) begin
        on_len_r <= '0;
      end else if (on_len_r != 9'h1FF) begin
        on_len_r <= on_len_r + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence write_to(logic [7:0] off);
    hit(wr_evt, wr_off, off);
  endsequence

  sequence quiet_cycle;
    !wr_evt;
  endsequence

  cfg_hold_a: assert property (quiet_cycle |=> $stable(delay_cfg_r) && $stable(loop_cfg_r))
    else $error("config changed without a write");

  coarse_join_a: assert property (write_to(spindle_pkg::OFF_COARSE) |=>
    coarse_count_o[11:4] == last_wr_r)
    else $error("coarse high bits misplaced");

  split_reg_a: assert property (write_to(spindle_pkg::OFF_CF) |=>
    coarse_count_o[3:0] == last_wr_r[7:4] && fine_count_o[10:8] == last_wr_r[2:0]
    && brake_two_phase_o == last_wr_r[3])
    else $error("coarse/fine split wrong");

  fine_join_a: assert property (write_to(spindle_pkg::OFF_FINE) |=>
    fine_count_o[7:0] == last_wr_r)
    else $error("fine low bits misplaced");

  commut_map_a: assert property (write_to(spindle_pkg::OFF_DELAY) |=> ##1
    commut_delay_o == {last_wr_r[4], last_wr_r[5], last_wr_r[6], last_wr_r[7]}
    && pole8_o == last_wr_r[3])
    else $error("commutation code wrong");

  commut_deg_a: assert property (commut_delay_mdeg_o ==
    15'((int'(commut_delay_o) + 1) * spindle_pkg::COMMUT_STEP_MDEG) || $changed(commut_delay_o))
    else $error("commutation degrees wrong");

  mask_sel_a: assert property (write_to(spindle_pkg::OFF_DELAY) |=> ##1
    mask_window_mdeg_o == (last_wr_r[0] ? 14'(spindle_pkg::MASK_NARROW_MDEG)
                                        : 14'(spindle_pkg::MASK_WIDE_MDEG)))
    else $error("mask window wrong");

  pump_force_a: assert property (write_to(spindle_pkg::OFF_LOOP) |=>
    pump_force_down_o == last_wr_r[6] && pump_force_up_o == last_wr_r[7])
    else $error("pump force bits wrong");

  limit_map_a: assert property (write_to(spindle_pkg::OFF_LOOP) |=> ##1
    limit_mv_o == spindle_pkg::LIMIT_MV[{last_wr_r[3], last_wr_r[5], last_wr_r[4]}])
    else $error("sense limit wrong");

  zc_route_a: assert property (1 |=> zero_cross_out_o ==
    ($past(sense_out_select_o) ? $past(sync_r[S_SENSE]) : $past(sync_r[S_ZC])))
    else $error("zero-cross pin source wrong");

  thermal_off_a: assert property (status_r[spindle_pkg::ST_THERM] == spindle_drive_en_o
    and (!spindle_drive_en_o |=> !pwm_gate_o))
    else $error("drivers active in thermal shutdown");

  speed_err_a: assert property (spd_cnt_r == SPD_MAX - 1'b1 && !zc_rise |=> ##2
    !status_r[spindle_pkg::ST_SPEED])
    else $error("speed error not flagged");

  min_on_a: assert property ($fell(pwm_gate_o) && spindle_drive_en_o |->
    on_len_r >= min_on_cycles_o)
    else $error("PWM pulse below minimum on-time");

  min_start_a: assert property ($rose(pwm_gate_o) |->
    (pwm_gate_o || !spindle_drive_en_o)[*8])
    else $error("PWM pulse ended too soon");
endmodule : spindle_config_status_regs

// file: host_model.sv
// Host serial master driving the register bank port
`timescale 1ns/10ps
module host_model (
  output logic sclk_o,
  output logic sen_o,
  output logic serial_data_io_o,
  input wire logic serial_data_io_i,
  input wire logic serial_data_io_oe_i
);
  initial begin
    sclk_o = 1'b0;
    sen_o = 1'b0;
    serial_data_io_o = 1'b0;
  end
  // LSB first, clock only in frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
    rd = 8'h00;
    sen_o = 1'b1;
    for (int i = 0; i < n; i++) begin
      serial_data_io_o = w[i % 16];
      #80;
      if (i >= 8 && i < 16)
        rd[i - 8] = serial_data_io_oe_i ? serial_data_io_i : ~serial_data_io_i;
      sclk_o = 1'b1;
      #80;
      sclk_o = 1'b0;
    end
    // drop enable, gap over 200 ns
    #40;
    sen_o = 1'b0;
    serial_data_io_o = ~serial_data_io_o;
    #250;
  endtask : xfer
endmodule : host_model

// file: testbench.sv
// Self-checking bench for the spindle register bank
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, zc = 1'b0, sclk, sen, sdi, sdo, sdoe;
  logic zc_run = 1'b1, sa = 1'b1, pw = 1'b0, zo, pg;
  logic [6:0] st = 7'h00;
  logic [13:0] mw;
  logic [8:0] mo;
  logic [3:0] cd;
  logic [14:0] cdm;
  logic [11:0] cc;
  logic [10:0] fc;
  logic [9:0] lm;
  logic p8, br, sl, pi, so, lt, pd, pu, de;
  logic [7:0] d;
  logic [2:0] k;
  int num_checks = 0, miscompares = 0, cyc = 0;
  int mon[4] = '{236, 56, 480, 209};
  int lmv[8] = '{450, 500, 550, 750, 150, 200, 250, 300};
  logic [7:0] dv[4] = '{8'h00, 8'h12, 8'h84, 8'hFF};
  spindle_config_status_regs #(.SPEED_LIMIT_CYC(64)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .sclk_i(sclk), .serial_frame_enable_i(sen), .serial_data_i(sdi), .serial_data_o(sdo),
    .serial_data_oe_o(sdoe), .overtemp_i(st[0]), .overtemp_early_i(st[1]),
    .rotor_stall_i(st[2]), .spin_fault_i(st[3]), .bemf_masked_i(st[4]),
    .align_phase_i(st[5]), .go_phase_i(st[6]), .zero_cross_i(zc), .sense_amp_i(sa),
    .pwm_req_i(pw), .mask_window_mdeg_o(mw), .min_on_cycles_o(mo), .pole8_o(p8),
    .commut_delay_o(cd), .commut_delay_mdeg_o(cdm), .coarse_count_o(cc),
    .fine_count_o(fc), .brake_two_phase_o(br), .chop_edge_rate_sel_o(sl),
    .pump_current_sel_o(pi), .sense_out_select_o(so), .limit_third_o(lt),
    .limit_mv_o(lm), .pump_force_down_o(pd), .pump_force_up_o(pu),
    .zero_cross_out_o(zo), .spindle_drive_en_o(de), .pwm_gate_o(pg));
  host_model host (.sclk_o(sclk), .sen_o(sen), .serial_data_io_o(sdi), .serial_data_io_i(sdo),
    .serial_data_io_oe_i(sdoe));
  always #12.5 clk_i = ~clk_i;
  // Zero-cross period well inside the shortened speed limit
  always #250 if (zc_run) zc = ~zc;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input int n = 16);
    logic [7:0] r;
    host.xfer({v, a}, n, r);
    repeat (8) @(negedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.xfer({8'h00, a | 8'h01}, 16, r);
    chk("read", {8'h00, e}, {8'h00, r});
  endtask : rd
  initial begin
    // Three edges of reset to satisfy the link synchroniser
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    foreach (dv[i]) begin
      d = dv[i];
      wr(spindle_pkg::OFF_DELAY, d);
      chk("mask", 16'(d[0] ? 7500 : 15000), 16'(mw));
      chk("minon", 16'(mon[{d[2], d[1]}]), 16'(mo));
      chk("pole", 16'(d[3]), 16'(p8));
      chk("delay", 16'({d[4], d[5], d[6], d[7]}), 16'(cd));
      chk("degrees", 16'((16'({d[4], d[5], d[6], d[7]}) + 1) * 1875), 16'(cdm));
    end
    wr(spindle_pkg::OFF_DELAY, 8'h00, 10);
    chk("abort", 16'h000F, 16'(cd));
    wr(spindle_pkg::OFF_DELAY, 8'h12, 18);
    chk("extra", 16'h0008, 16'(cd));
    $display("test delay done");
    wr(spindle_pkg::OFF_COARSE, 8'hA5);
    wr(spindle_pkg::OFF_CF, 8'h6D);
    wr(spindle_pkg::OFF_FINE, 8'h3C);
    chk("coarse", 16'h0A56, 16'(cc));
    chk("fine", 16'h053C, 16'(fc));
    chk("brake", 16'h0001, 16'(br));
    $display("test counters done");
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      wr(spindle_pkg::OFF_LOOP, {~k[2], k[2], k[1], k[0], k[2], 1'b0, k[1], k[0]});
      chk("limit", 16'(lmv[k]), 16'(lm));
      chk("loop", 16'({~k[2], k[2], k[2], k[2], k[1], k[0]}), 16'({pu, pd, so, lt, pi, sl}));
    end
    $display("test loop done");
    for (int i = 0; i < 2; i++) begin
      st = i ? 7'h7F : 7'h00;
      repeat (10) @(negedge clk_i);
      rd(spindle_pkg::OFF_STATUS, {~st[6], ~st[5], 1'b1, ~st[4], st[3], ~st[2:0]});
      chk("drive", 16'(!st[0]), 16'(de));
    end
    // Stopped zero crossings must raise the speed error
    st = 7'h00;
    zc_run = 1'b0;
    repeat (100) @(negedge clk_i);
    rd(spindle_pkg::OFF_STATUS, 8'hD7);
    sa = 1'b0;
    repeat (5) @(negedge clk_i);
    chk("zcsense0", 16'h0000, 16'(zo));
    sa = 1'b1;
    repeat (5) @(negedge clk_i);
    chk("zcsense1", 16'h0001, 16'(zo));
    wr(spindle_pkg::OFF_LOOP, 8'h00);
    chk("zcpin", 16'(zc), 16'(zo));
    // One-cycle request still held for the minimum on-time
    pw = 1'b1;
    @(negedge clk_i);
    pw = 1'b0;
    repeat (20) @(negedge clk_i);
    chk("minon_hold", 16'h0001, 16'(pg));
    repeat (60) @(negedge clk_i);
    chk("minon_end", 16'h0000, 16'(pg));
    rd(spindle_pkg::OFF_DELAY, 8'h00);
    $display("test status done");
    summarize();
  end
endmodule : testbench
